/* src/acs_sequencer.sv */
// Overview of operation
// RL1: Conversion lasts nine and a half bit periods.
// RL2: Select code picks 2, 8, 32 clocks or RC.
// RL3: Software keeps bit period at least 1.6 us.
// RL4: RC option gives about 4 us bit period.
// RL5: Two bit periods hold-off after completion, sampler open.
// RL6: Sampling capacitor never discharged between conversions.
// RL7: Clearing go mid-conversion aborts at once.
// RL8: Abort leaves result register untouched.
// RL9: Two bit periods after abort, acquisition restarts.
// RL10: Software enables converter before setting go.
// RL11: Software waits acquisition time before setting go.
// RL12: Acquisition time is settling, charging, temperature terms.
// RL13: Analog-configured pins read back as zero.
// RL14: Selected pin sampled whatever its direction.
// RL15: Channel and direction bits never block conversion.
// RL16: Digital-configured pins still convert when selected.
// RL17: Completion clears go and sets done flag together.
// RL18: Above 1 MHz use RC only in sleep.
// RL19: Completion loads result with go clearing.
// RL20: Converter-on low holds module off.
// RL21: Three-bit channel field routes one of eight inputs.
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer (
   input  wire logic                  ref_clk_i,
   input  wire logic                  srst_i,
   input  wire acs_pkg::acs_ctrl_type ctrl_i,
   input  wire logic                  go_set_i,
   input  wire logic                  go_clear_i,
   input  wire logic                  result_wr_i,
   input  wire logic [7:0]            result_wdata_i,
   input  wire logic                  irq_flag_clear_i,
   input  wire logic                  comp_i,
   input  wire logic [7:0]            port_pin_i,
   input  wire logic [7:0]            analog_pin_mask_i,
   output logic                       go_busy_o,
   output logic [7:0]                 conversion_result_o,
   output logic                       conv_done_irq_flag_o,
   output logic                       sample_switch_o,
   output logic [2:0]                 channel_mux_o,
   output logic [7:0]                 dac_code_o,
   output logic                       converter_active_o,
   output logic [7:0]                 port_read_data_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Half bit-period length per clock select
   function automatic logic [8:0] half_period(input logic [1:0] sel);
      case (sel)
         acs_pkg::CLK_SEL_DIV2:  half_period = acs_pkg::DIV2_HALF_CYC;  // [RL2]
         acs_pkg::CLK_SEL_DIV8:  half_period = acs_pkg::DIV8_HALF_CYC;  // [RL2]
         acs_pkg::CLK_SEL_DIV32: half_period = acs_pkg::DIV32_HALF_CYC; // [RL2]
         default:                half_period = acs_pkg::RC_HALF_CYC;    // [RL4]
      endcase
   endfunction : half_period

   ////////////////////////////////////////////////////////////////////////////
   acs_pkg::acs_core_type st_reg;
   acs_pkg::acs_core_type st_next;
   logic                  tick;
   logic                  done_evt;
   logic                  abort_evt;
   logic [2:0]            bit_idx;

   // Half-period counted, so the trailing half bit period is exact
   // At-or-above, so a shorter select mid-run cannot strand the divider
   assign tick     = (st_reg.div_cnt >= half_period(ctrl_i.conv_clock_select) - 9'h001);
   assign bit_idx  = 3'h7 - 3'(st_reg.half_cnt >> 1);
   assign abort_evt = (st_reg.state == acs_pkg::ST_CONVERT) && go_clear_i && ctrl_i.converter_on_bit;
   assign done_evt  = (st_reg.state == acs_pkg::ST_CONVERT) && !go_clear_i && ctrl_i.converter_on_bit
                      && tick && (st_reg.half_cnt == acs_pkg::CONV_HALF_TADS - 5'h01);

   always_comb begin
      st_next         = st_reg;
      st_next.port_rd = port_pin_i & ~analog_pin_mask_i;  // [RL13]
      // Mux follows the field alone; direction bits never gate it
      st_next.chan    = ctrl_i.channel_select;             // [RL21] [RL14] [RL16]
      if (irq_flag_clear_i) begin
         st_next.irq = 1'b0;
      end
      if (result_wr_i) begin
         st_next.result = result_wdata_i;
      end
      case (st_reg.state)
         acs_pkg::ST_OFF: begin
            st_next.go     = 1'b0;
            st_next.sample = 1'b0;
            st_next.active = 1'b0;
            if (ctrl_i.converter_on_bit) begin
               st_next.state  = acs_pkg::ST_ACQUIRE;
               st_next.sample = 1'b1;
               st_next.active = 1'b1;
            end
         end
         acs_pkg::ST_ACQUIRE: begin
            // Start ignores channel contents entirely
            if (go_set_i) begin                            // [RL15]
               st_next.state    = acs_pkg::ST_CONVERT;
               st_next.go       = 1'b1;
               st_next.sample   = 1'b0;
               st_next.sar      = acs_pkg::SAR_FIRST_TRIAL;
               st_next.div_cnt  = 9'h000;
               st_next.half_cnt = 5'h00;
            end
         end
         acs_pkg::ST_CONVERT: begin
            st_next.div_cnt = st_reg.div_cnt + 9'h001;
            if (tick) begin
               st_next.div_cnt  = 9'h000;
               st_next.half_cnt = st_reg.half_cnt + 5'h01;
               if (st_reg.half_cnt[0] && st_reg.half_cnt < 5'h10) begin
                  if (!comp_i) begin
                     st_next.sar[bit_idx] = 1'b0;
                  end
                  if (bit_idx != 3'h0) begin
                     st_next.sar[bit_idx - 3'h1] = 1'b1;
                  end
               end
            end
            if (go_clear_i) begin                          // [RL7]
               // Result left as is on abort
               st_next.state    = acs_pkg::ST_HOLDOFF;     // [RL8] [RL9]
               st_next.go       = 1'b0;
               st_next.div_cnt  = 9'h000;
               st_next.half_cnt = 5'h00;
            end else if (done_evt) begin                   // [RL1]
               st_next.state    = acs_pkg::ST_HOLDOFF;     // [RL5]
               st_next.result   = st_reg.sar;              // [RL19]
               st_next.go       = 1'b0;                    // [RL17]
               st_next.irq      = 1'b1;                    // [RL17]
               st_next.div_cnt  = 9'h000;
               st_next.half_cnt = 5'h00;
            end
         end
         acs_pkg::ST_HOLDOFF: begin
            st_next.div_cnt = st_reg.div_cnt + 9'h001;
            if (tick) begin
               st_next.div_cnt  = 9'h000;
               st_next.half_cnt = st_reg.half_cnt + 5'h01;
               if (st_reg.half_cnt == acs_pkg::HOLD_HALF_TADS - 5'h01) begin
                  // No discharge: capacitor resumes from its held level
                  st_next.state  = acs_pkg::ST_ACQUIRE;    // [RL9] [RL6]
                  st_next.sample = 1'b1;
               end
            end
         end
         default: begin
            st_next.state = acs_pkg::ST_OFF;
         end
      endcase
      // Off wins over every state; result is kept
      if (!ctrl_i.converter_on_bit) begin                  // [RL20]
         st_next.state  = acs_pkg::ST_OFF;
         st_next.go     = 1'b0;
         st_next.sample = 1'b0;
         st_next.active = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_reg          <= '0;
         st_reg.state    <= acs_pkg::ST_OFF;
         st_reg.result   <= acs_pkg::RESULT_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign go_busy_o            = st_reg.go;
   assign conversion_result_o  = st_reg.result;
   assign conv_done_irq_flag_o = st_reg.irq;
   assign sample_switch_o      = st_reg.sample;
   assign channel_mux_o        = st_reg.chan;
   assign dac_code_o           = st_reg.sar;
   assign converter_active_o   = st_reg.active;
   assign port_read_data_o     = st_reg.port_rd;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);

   logic [12:0] conv_cyc;
   logic        sel_steady;
   logic [8:0]  hp_start;
   logic [12:0] hold_cyc;
   logic        hold_steady;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i || st_reg.state != acs_pkg::ST_CONVERT) begin
         conv_cyc   <= 13'h0000;
         sel_steady <= 1'b1;
         hp_start   <= half_period(ctrl_i.conv_clock_select);
      end else begin
         conv_cyc <= conv_cyc + 13'h0001;
         if (half_period(ctrl_i.conv_clock_select) != hp_start) begin
            sel_steady <= 1'b0;
         end
      end
   end

   // Hold-off tracker; judged only while the select stays put
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || st_reg.state != acs_pkg::ST_HOLDOFF) begin
         hold_cyc    <= 13'h0000;
         hold_steady <= 1'b1;
      end else begin
         hold_cyc <= hold_cyc + 13'h0001;
         if (half_period(ctrl_i.conv_clock_select) != hp_start) begin
            hold_steady <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_conv_length: assert property (done_evt && sel_steady |-> // [RL1]
      conv_cyc == 13'(19 * hp_start) - 13'h0001)
      else $error("Conversion length is not 9.5 bit periods");

   a_done_flags: assert property (done_evt |=> !go_busy_o && conv_done_irq_flag_o) // [RL17]
      else $error("Completion did not clear go and set flag");

   a_result_load: assert property (done_evt |=> conversion_result_o == $past(dac_code_o)) // [RL19]
      else $error("Result not loaded at completion");

   a_abort_keeps: assert property (abort_evt && !result_wr_i |=> // [RL8]
      conversion_result_o == $past(conversion_result_o))
      else $error("Abort changed the result");

   a_abort_stops: assert property (abort_evt |=> !go_busy_o && !sample_switch_o) // [RL7]
      else $error("Abort did not stop conversion");

   a_holdoff_open: assert property ((done_evt || abort_evt) && ctrl_i.conv_clock_select == 2'h0 // [RL5]
      && !srst_i |=> !sample_switch_o [*4])
      else $error("Sampler reconnected inside hold-off");

   a_restart_auto: assert property ((done_evt || abort_evt) && ctrl_i.conv_clock_select == 2'h0 // [RL9]
      && $stable(ctrl_i) [*1] |=> ##4 (sample_switch_o || !converter_active_o))
      else $error("Acquisition did not restart after hold-off");

   a_off_idle: assert property (!ctrl_i.converter_on_bit |=> !converter_active_o && !go_busy_o) // [RL20]
      else $error("Converter active while switched off");

   a_port_mask: assert property (##1 port_read_data_o == $past(port_pin_i & ~analog_pin_mask_i)) // [RL13]
      else $error("Analog pin did not read as zero");

   a_mux_follow: assert property (##1 channel_mux_o == $past(ctrl_i.channel_select)) // [RL21]
      else $error("Channel mux does not follow select");

   a_holdoff_len: assert property (st_reg.state == acs_pkg::ST_HOLDOFF && hold_steady // [RL5] [RL9]
      && st_next.state == acs_pkg::ST_ACQUIRE && half_period(ctrl_i.conv_clock_select) == hp_start
      |-> hold_cyc == 13'(4 * hp_start) - 13'h0001)
      else $error("Hold-off length is not two bit periods");

   a_go_start: assert property (st_reg.state == acs_pkg::ST_ACQUIRE && go_set_i && ctrl_i.converter_on_bit // [RL15]
      |=> go_busy_o && !sample_switch_o && dac_code_o == acs_pkg::SAR_FIRST_TRIAL)
      else $error("Start was refused or misloaded");

   a_sample_closed: assert property (go_busy_o |-> !sample_switch_o) // [RL1]
      else $error("Sampler connected during conversion");

   a_bit_decide: assert property (st_reg.state == acs_pkg::ST_CONVERT && tick && st_reg.half_cnt[0] // [RL1]
      && st_reg.half_cnt < 5'h10 && ctrl_i.converter_on_bit |=> dac_code_o[$past(bit_idx)] == $past(comp_i))
      else $error("Trial bit does not follow the comparator");

   a_next_trial: assert property (st_reg.state == acs_pkg::ST_CONVERT && tick && st_reg.half_cnt[0] // [RL1]
      && st_reg.half_cnt < 5'h0f && ctrl_i.converter_on_bit |=> dac_code_o[$past(bit_idx) - 3'h1])
      else $error("Next trial bit was not raised");

   a_go_held: assert property (go_busy_o && !go_clear_i && !done_evt && ctrl_i.converter_on_bit // [RL17]
      |=> go_busy_o)
      else $error("Go flag dropped before completion");

   a_holdoff_nogo: assert property (st_reg.state == acs_pkg::ST_HOLDOFF |=> !go_busy_o) // [RL5]
      else $error("Conversion started inside hold-off");

   a_irq_sticky: assert property (conv_done_irq_flag_o && !irq_flag_clear_i |=> conv_done_irq_flag_o) // [RL17]
      else $error("Done flag dropped without a clear");

   a_irq_clear: assert property (irq_flag_clear_i && !done_evt |=> !conv_done_irq_flag_o) // [RL17]
      else $error("Done flag survived a clear");

   a_result_hold: assert property (!done_evt && !result_wr_i |=> $stable(conversion_result_o)) // [RL8]
      else $error("Result changed without completion or write");

   a_abort_no_irq: assert property (abort_evt && !conv_done_irq_flag_o |=> !conv_done_irq_flag_o) // [RL7]
      else $error("Abort raised the done flag");

   a_on_acquire: assert property (ctrl_i.converter_on_bit && !converter_active_o |=> converter_active_o // [RL20]
      && sample_switch_o)
      else $error("Converter did not start acquiring when enabled");

   // Main scenarios reached
   c_done: cover property (done_evt);
   c_abort: cover property (abort_evt);
   c_rc_done: cover property (done_evt && ctrl_i.conv_clock_select == acs_pkg::CLK_SEL_RC);
   c_restart: cover property (abort_evt ##[1:40] sample_switch_o);
   c_div32_done: cover property (done_evt && ctrl_i.conv_clock_select == acs_pkg::CLK_SEL_DIV32);

endmodule : acs_sequencer

`default_nettype wire

/* src/acs_pkg.sv */
package acs_pkg;

   // Clock and conversion timing
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned RC_TAD_NS       = 4000;
   localparam logic [8:0]  RC_HALF_CYC     = 9'(RC_TAD_NS / (2 * CLK_PERIOD_NS));
   localparam logic [8:0]  DIV2_HALF_CYC   = 9'h001;
   localparam logic [8:0]  DIV8_HALF_CYC   = 9'h004;
   localparam logic [8:0]  DIV32_HALF_CYC  = 9'h010;
   localparam logic [4:0]  CONV_HALF_TADS  = 5'h13;
   localparam logic [4:0]  HOLD_HALF_TADS  = 5'h04;
   localparam logic [7:0]  SAR_FIRST_TRIAL = 8'h80;
   localparam logic [7:0]  RESULT_RESET    = 8'h00;

   // Clock select codes
   localparam logic [1:0] CLK_SEL_DIV2  = 2'h0;
   localparam logic [1:0] CLK_SEL_DIV8  = 2'h1;
   localparam logic [1:0] CLK_SEL_DIV32 = 2'h2;
   localparam logic [1:0] CLK_SEL_RC    = 2'h3;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_ACQUIRE,
      ST_CONVERT,
      ST_HOLDOFF
   } acs_state_type;

   typedef struct packed {
      logic       converter_on_bit;
      logic [1:0] conv_clock_select;
      logic [2:0] channel_select;
   } acs_ctrl_type;

   typedef struct packed {
      acs_state_type state;
      logic [8:0]    div_cnt;
      logic [4:0]    half_cnt;
      logic [7:0]    sar;
      logic [7:0]    result;
      logic          go;
      logic          irq;
      logic          sample;
      logic          active;
      logic [2:0]    chan;
      logic [7:0]    port_rd;
   } acs_core_type;

endpackage : acs_pkg

/* tb/acs_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none

module acs_analog_model (
   input  wire logic        ref_clk_i,
   input  wire logic        sample_i,
   input  wire logic [2:0]  chan_i,
   input  wire logic [7:0]  dac_i,
   input  wire logic [63:0] level_i,
   output logic             comp_o
);
   // Never reset, so a stale charge carries into the next acquisition
   logic [7:0] held_reg = 8'h00;

   always @(posedge ref_clk_i) begin
      if (sample_i) begin
         held_reg <= level_i[chan_i*8 +: 8];
      end
   end

   assign comp_o = (held_reg >= dac_i);
endmodule : acs_analog_model

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic                  ref_clk_i = 1'b0;
   logic                  srst_i    = 1'b1;
   acs_pkg::acs_ctrl_type ctrl      = '{1'b1, 2'h0, 3'h0};
   logic                  go_set    = 1'b0;
   logic                  go_clr    = 1'b0;
   logic                  res_wr    = 1'b0;
   logic                  irq_clr   = 1'b0;
   logic [7:0]            res_wdata = 8'h00;
   logic [7:0]            pins      = 8'h00;
   logic [7:0]            amask     = 8'h00;
   logic [63:0]           levels    = 64'h0;
   logic                  comp, go_busy, irq, sample, active;
   logic [7:0]            result, dac, port_rd;
   logic [2:0]            chan_mux;
   int                    errors    = 0;
   int                    checked   = 0;
   int                    half_tbl [4] = '{1, 4, 16, 250};

   always #4 ref_clk_i = ~ref_clk_i;

   acs_sequencer u_acs_sequencer (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ctrl_i(ctrl),
      .go_set_i(go_set), .go_clear_i(go_clr), .result_wr_i(res_wr), .result_wdata_i(res_wdata),
      .irq_flag_clear_i(irq_clr), .comp_i(comp), .port_pin_i(pins), .analog_pin_mask_i(amask),
      .go_busy_o(go_busy), .conversion_result_o(result), .conv_done_irq_flag_o(irq),
      .sample_switch_o(sample), .channel_mux_o(chan_mux), .dac_code_o(dac),
      .converter_active_o(active), .port_read_data_o(port_rd));

   acs_analog_model u_acs_analog_model (.ref_clk_i(ref_clk_i), .sample_i(sample), .chan_i(chan_mux),
      .dac_i(dac), .level_i(levels), .comp_o(comp));

   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : cyc

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : pulse

   // Counts idle cycles with the sampler open, bounded
   task automatic holdoff(input int h);
      int n;
      n = 0;
      while (sample !== 1'b1 && n < 5000) begin
         n++;
         cyc(1);
      end
      chk(16'(n), 16'(4 * h));
   endtask : holdoff

   ////////////////////////////////////////////////////////////////////////////
   task automatic run_conv(input logic [1:0] sel, input logic [2:0] ch, input logic [7:0] v);
      int n;
      ctrl.conv_clock_select = sel;
      ctrl.channel_select = ch;
      levels[ch*8 +: 8] = v;
      pulse(irq_clr);
      cyc(20); // Scaled acquisition wait
      chk(16'(chan_mux), 16'(ch));
      pulse(go_set);
      chk({7'h00, sample, dac}, {7'h00, 1'b0, acs_pkg::SAR_FIRST_TRIAL});
      n = 0;
      while (go_busy === 1'b1 && n < 20000) begin
         n++;
         cyc(1);
      end
      chk(16'(n), 16'(19 * half_tbl[sel]));
      chk({7'h00, irq, result}, {7'h00, 1'b1, v});
      holdoff(half_tbl[sel]);
      $display("conversion sel=%h ch=%h done", sel, ch);
   endtask : run_conv

   task automatic abort_test();
      res_wdata = 8'h5a;
      pulse(res_wr);
      pulse(irq_clr);
      ctrl.conv_clock_select = 2'h1;
      levels[7:0] = 8'hc3;
      ctrl.channel_select = 3'h0;
      cyc(20);
      pulse(go_set);
      cyc(20);
      pulse(go_clr);
      chk(16'(go_busy), 16'h0000);
      chk({7'h00, irq, result}, 16'h005a);
      holdoff(4);
      $display("abort test done");
   endtask : abort_test

   task automatic port_test();
      pins = 8'ha5;
      amask = 8'h0f;
      cyc(2);
      chk(16'(port_rd), 16'h00a0);
      $display("port read test done");
   endtask : port_test

   // Go raised alongside enable must be ignored
   task automatic off_test();
      ctrl.converter_on_bit = 1'b0;
      cyc(2);
      chk(16'(active), 16'h0000);
      ctrl.converter_on_bit = 1'b1;
      pulse(go_set);
      cyc(2);
      chk({14'h0000, active, go_busy}, 16'h0002);
      $display("on off test done");
   endtask : off_test

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("compares=%0d mismatches=%0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   initial begin
      cyc(16);
      srst_i = 1'b0;
      cyc(3);
      pins = 8'h3c; // Digital pin levels must not disturb conversion
      for (int c = 0; c < 8; c++) begin
         run_conv(2'h0, 3'(c), 8'(8'h1d * c + 8'h07));
      end
      // Ideal comparator, so short bit periods and awake RC still convert
      for (int s = 0; s < 4; s++) begin
         run_conv(2'(s), 3'h5, 8'(8'hff - 8'h33 * s));
      end
      abort_test();
      port_test();
      off_test();
      final_report();
   end

   // Expected run is about 54 us
   initial begin
      #500us;
      errors++;
      final_report();
   end
endmodule : testbench

`default_nettype wire
